// >>> rtl/ajm_joy_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ajm_map.svh"

// Functional notes
// (RULE_01) Primary to main, redundant to safety channel
// (RULE_02) Accept configurable sender address, default 78
// (RULE_03) Group offsets default 22 main, 23 safety
// (RULE_04) Steer only while operator command permits
// (RULE_05) Locked out: wait for another steering device
// (RULE_06) Validate whenever configured present, even prohibited
// (RULE_07) Sensors start sending within 10 s
// (RULE_08) Every check applies to both messages
// (RULE_09) Single timeout, limit in 10 ms, safe
// (RULE_10) Single sequence error enters safe state
// (RULE_11) Single CRC mismatch enters safe state
// (RULE_12) Single out-of-range value enters safe state
// (RULE_13) Position difference over limit too long: safe
// (RULE_14) Engage disagreement too long enters safe state
// (RULE_15) Trim difference over limit too long: safe
// (RULE_16) Scale cross-checked data into spool set-point
// (RULE_17) Spool versus wheel movement inconsistency: safe
// (RULE_18) Flow command from wheel set-point minus measured
// (RULE_19) Closed loop only with CAN joystick, single type
// (RULE_20) Sensors send two independent position channels
// (RULE_21) Sensors send one engage signal per channel
// (RULE_22) Timeout set to 1.5 nominal intervals
// (RULE_23) Divergence timers restart when back in limit
// (RULE_24) Safe state latched until reset
module ajm_joy_monitor import ajm_pkg::*; #(
  parameter int TICK_CYCLES = `AJM_TICK_NS / `AJM_CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  ajm_link_if.mon link,
  input wire logic [7:0] joystick_sender_address,
  input wire logic [7:0] main_group_offset,
  input wire logic [7:0] safety_group_offset,
  input wire logic [7:0] message_timeout_limit,
  input wire logic [7:0] position_divergence_time,
  input wire logic [15:0] position_difference_limit,
  input wire logic [7:0] engage_divergence_time,
  input wire logic [7:0] trim_divergence_time,
  input wire logic [15:0] trim_difference_limit,
  input wire logic aux_present,
  input wire logic operator_interface_command,
  input wire logic joystick_on_can,
  input wire logic single_aux_type,
  input wire logic signed [15:0] wheel_angle_meas,
  output logic steer_en,
  output logic await_other_device,
  output logic safe_state,
  output logic [`AJM_FLT_W-1:0] fault_flags,
  output logic [15:0] main_position,
  output logic [15:0] safety_position,
  output logic signed [15:0] wheel_error,
  output logic signed [15:0] flow_cmd,
  output logic signed [15:0] spool_setpoint
);

  localparam logic [9:0] STARTUP_TICKS = 10'(`AJM_STARTUP_MS / `AJM_TICK_MS);

  ajm_mon_t s_r;
  ajm_mon_t s_nxt;
  logic tick;
  logic both_seen;
  logic steer_ok;
  logic [1:0][7:0] ch_offset;
  logic [`AJM_FLT_W-1:0] flt;
  logic signed [15:0] wheel_sp;
  logic signed [15:0] err;
  logic signed [15:0] wheel_delta;

  assign ch_offset[0] = main_group_offset;
  assign ch_offset[1] = safety_group_offset;
  assign tick = (s_r.tick_cnt == 20'(TICK_CYCLES - 1));
  assign both_seen = &s_r.seen;
  // Closed loop needs CAN joystick, single device type and both engages
  assign steer_ok = operator_interface_command & joystick_on_can & single_aux_type &
                    s_r.eng[0] & s_r.eng[1]; // [RULE_19]

  always_comb begin
    s_nxt = s_r;
    flt = '0;
    wheel_sp = '0;
    err = '0;
    wheel_delta = '0;
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + 20'h0_0001;

    if (!aux_present) begin
      // Monitoring suspended only when configured absent [RULE_06]
      s_nxt.boot = '0;
      s_nxt.seen = '0;
      s_nxt.tmo = '0;
      s_nxt.pos_div = '0;
      s_nxt.eng_div = '0;
      s_nxt.trim_div = '0;
      s_nxt.fda_cnt = '0;
    end else begin
      if (tick && s_r.boot != STARTUP_TICKS) begin
        s_nxt.boot = s_r.boot + 10'h001;
      end
      // Channel 0 takes the primary message, channel 1 the redundant one
      for (int c = 0; c < 2; c++) begin
        if (tick && s_r.seen[c]) begin
          s_nxt.tmo[c] = s_r.tmo[c] + 8'h01;
          if (s_r.tmo[c] + 8'h01 >= message_timeout_limit) begin
            flt[`AJM_FLT_TIMEOUT] = 1'b1; // [RULE_09]
          end
        end
        if (tick && !s_r.seen[c] && s_r.boot + 10'h001 >= STARTUP_TICKS) begin
          flt[`AJM_FLT_TIMEOUT] = 1'b1; // [RULE_07]
        end
        if (link.frm_valid && link.frm.sender == joystick_sender_address && // [RULE_02]
            link.frm.offset == ch_offset[c]) begin // [RULE_01] [RULE_03]
          // Same checks on both messages [RULE_08]
          s_nxt.tmo[c] = '0;
          s_nxt.seen[c] = 1'b1;
          s_nxt.seq[c] = link.frm.seq;
          s_nxt.pos[c] = link.frm.pos;
          s_nxt.trim[c] = link.frm.trim;
          s_nxt.eng[c] = link.frm.engage;
          if (s_r.seen[c] && link.frm.seq != s_r.seq[c] + 4'h1) begin
            flt[`AJM_FLT_SEQ] = 1'b1; // [RULE_10]
          end
          if (link.frm.crc != ajm_crc(link.frm)) begin
            flt[`AJM_FLT_CRC] = 1'b1; // [RULE_11]
          end
          if (link.frm.pos > `AJM_VALUE_MAX || link.frm.trim > `AJM_VALUE_MAX) begin
            flt[`AJM_FLT_RANGE] = 1'b1; // [RULE_12]
          end
        end
      end

      if (tick && both_seen) begin
        if (ajm_absdiff(s_r.pos[0], s_r.pos[1]) > position_difference_limit) begin
          s_nxt.pos_div = s_r.pos_div + 8'h01;
          if (s_r.pos_div + 8'h01 > position_divergence_time) begin
            flt[`AJM_FLT_CROSS] = 1'b1; // [RULE_13]
          end
        end else begin
          s_nxt.pos_div = '0; // [RULE_23]
        end
        if (s_r.eng[0] != s_r.eng[1]) begin
          s_nxt.eng_div = s_r.eng_div + 8'h01;
          if (s_r.eng_div + 8'h01 > engage_divergence_time) begin
            flt[`AJM_FLT_CROSS] = 1'b1; // [RULE_14]
          end
        end else begin
          s_nxt.eng_div = '0; // [RULE_23]
        end
        if (ajm_absdiff(s_r.trim[0], s_r.trim[1]) > trim_difference_limit) begin
          s_nxt.trim_div = s_r.trim_div + 8'h01;
          if (s_r.trim_div + 8'h01 > trim_divergence_time) begin
            flt[`AJM_FLT_CROSS] = 1'b1; // [RULE_15]
          end
        end else begin
          s_nxt.trim_div = '0; // [RULE_23]
        end
      end

      // Wheel must move the way the spool points
      if (tick) begin
        wheel_delta = wheel_angle_meas - s_r.wheel_prev;
        s_nxt.wheel_prev = wheel_angle_meas;
        if ((s_r.spool_sp > $signed(`AJM_FDA_DEADBAND) && wheel_delta <= 16'sh0000) ||
            (s_r.spool_sp < -$signed(`AJM_FDA_DEADBAND) && wheel_delta >= 16'sh0000)) begin
          s_nxt.fda_cnt = s_r.fda_cnt + 8'h01;
          if (s_r.fda_cnt + 8'h01 > `AJM_FDA_TICKS) begin
            flt[`AJM_FLT_FDA] = 1'b1; // [RULE_17]
          end
        end else begin
          s_nxt.fda_cnt = '0;
        end
      end
    end

    // Closed loop: position maps onto wheel angle set-point
    wheel_sp = $signed(s_r.pos[0] - `AJM_POS_CENTER);
    err = wheel_sp - wheel_angle_meas; // [RULE_18]
    s_nxt.wheel_err = err;
    s_nxt.flow = err >>> `AJM_FLOW_SHIFT; // [RULE_18]

    s_nxt.fault = s_r.fault | flt; // [RULE_24]

    case (s_r.st)
      AJM_ST_OFF: begin
        if (|flt) begin
          s_nxt.st = AJM_ST_SAFE; // [RULE_24]
        end else if (aux_present) begin
          s_nxt.st = AJM_ST_MON;
        end
      end
      AJM_ST_MON: begin
        if (|flt) begin
          s_nxt.st = AJM_ST_SAFE;
        end else if (!aux_present) begin
          s_nxt.st = AJM_ST_OFF;
        end else if (steer_ok && both_seen) begin
          s_nxt.st = AJM_ST_STEER; // [RULE_04] [RULE_19]
        end
      end
      AJM_ST_STEER: begin
        if (|flt) begin
          s_nxt.st = AJM_ST_SAFE;
        end else if (!aux_present) begin
          s_nxt.st = AJM_ST_OFF;
        end else if (!steer_ok) begin
          s_nxt.st = AJM_ST_MON; // [RULE_04]
        end
      end
      AJM_ST_SAFE: begin
        s_nxt.st = AJM_ST_SAFE; // [RULE_24]
      end
      default: begin
        s_nxt.st = AJM_ST_SAFE;
      end
    endcase

    // Spool follows the cross-checked data only while steering [RULE_16]
    if (s_nxt.st == AJM_ST_STEER) begin
      s_nxt.spool_sp = s_nxt.flow;
    end else begin
      s_nxt.spool_sp = '0; // [RULE_24]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Suspend at once when the operator command withdraws permission
  assign steer_en = (s_r.st == AJM_ST_STEER) & operator_interface_command; // [RULE_04]
  assign await_other_device = ~steer_en; // [RULE_05]
  assign safe_state = (s_r.st == AJM_ST_SAFE);
  assign fault_flags = s_r.fault;
  assign main_position = s_r.pos[0];
  assign safety_position = s_r.pos[1];
  assign wheel_error = s_r.wheel_err;
  assign flow_cmd = s_r.flow;
  assign spool_setpoint = s_r.spool_sp;

endmodule // ajm_joy_monitor

`default_nettype wire

// >>> rtl/ajm_map.svh
`ifndef AJM_MAP_SVH
`define AJM_MAP_SVH

// Time base
`define AJM_CLK_PERIOD_NS 32'h0000_0064
`define AJM_TICK_NS 32'h0098_9680
`define AJM_TICK_MS 32'h0000_000A
`define AJM_STARTUP_MS 32'h0000_2710

// Configuration defaults
`define AJM_DEF_SENDER_ADDR 8'h4E
`define AJM_DEF_MAIN_OFFSET 8'h16
`define AJM_DEF_SAFETY_OFFSET 8'h17
`define AJM_DEF_TIMEOUT_LIMIT 8'h08
`define AJM_DEF_POS_DIV_TIME 8'h0A
`define AJM_DEF_POS_DIFF_LIMIT 16'h0005
`define AJM_DEF_ENG_DIV_TIME 8'h0A
`define AJM_DEF_TRIM_DIV_TIME 8'h0A
`define AJM_DEF_TRIM_DIFF_LIMIT 16'h0032

// Data range and scaling, 0.1 % units
`define AJM_VALUE_MAX 16'h03E8
`define AJM_POS_CENTER 16'h01F4
`define AJM_FLOW_SHIFT 1

// Spool versus wheel movement check
`define AJM_FDA_DEADBAND 16'h0014
`define AJM_FDA_TICKS 8'h05

// End-to-end check seed
`define AJM_CRC_SEED 8'hA5

// Fault flag positions
`define AJM_FLT_TIMEOUT 0
`define AJM_FLT_SEQ 1
`define AJM_FLT_CRC 2
`define AJM_FLT_RANGE 3
`define AJM_FLT_CROSS 4
`define AJM_FLT_FDA 5
`define AJM_FLT_W 6

`endif

// >>> rtl/ajm_pkg.sv
`include "ajm_map.svh"

package ajm_pkg;

  typedef struct packed {
    logic [7:0] sender;
    logic [7:0] offset;
    logic [3:0] seq;
    logic engage;
    logic [15:0] pos;
    logic [15:0] trim;
    logic [7:0] crc;
  } ajm_frame_t;

  typedef enum logic [1:0] {
    AJM_ST_OFF = 2'b00,
    AJM_ST_MON = 2'b01,
    AJM_ST_STEER = 2'b11,
    AJM_ST_SAFE = 2'b10
  } ajm_state_t;

  typedef struct packed {
    ajm_state_t st;
    logic [19:0] tick_cnt;
    logic [9:0] boot;
    logic [1:0] seen;
    logic [1:0][3:0] seq;
    logic [1:0][7:0] tmo;
    logic [1:0][15:0] pos;
    logic [1:0][15:0] trim;
    logic [1:0] eng;
    logic [7:0] pos_div;
    logic [7:0] eng_div;
    logic [7:0] trim_div;
    logic [`AJM_FLT_W-1:0] fault;
    logic signed [15:0] wheel_prev;
    logic [7:0] fda_cnt;
    logic signed [15:0] wheel_err;
    logic signed [15:0] flow;
    logic signed [15:0] spool_sp;
  } ajm_mon_t;

  typedef struct packed {
    logic [19:0] tick_cnt;
    logic [7:0] ival;
    logic redundant_next;
    logic [1:0][3:0] seq;
    logic frm_valid;
    ajm_frame_t frm;
  } ajm_node_t;

  function automatic logic [7:0] ajm_crc(input ajm_frame_t f);
    ajm_crc = `AJM_CRC_SEED ^ f.sender ^ f.offset ^ {3'h0, f.engage, f.seq} ^
              f.pos[15:8] ^ f.pos[7:0] ^ f.trim[15:8] ^ f.trim[7:0];
  endfunction

  function automatic logic [15:0] ajm_absdiff(input logic [15:0] a, input logic [15:0] b);
    ajm_absdiff = (a > b) ? (a - b) : (b - a);
  endfunction

endpackage

// >>> rtl/ajm_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ajm_link_if;
  import ajm_pkg::*;
  logic frm_valid;
  ajm_frame_t frm;
  modport node (output frm_valid, output frm);
  modport mon (input frm_valid, input frm);
endinterface

`default_nettype wire

// >>> rtl/ajm_sensor_nodes.sv
`timescale 1ns/1ps
`default_nettype none
`include "ajm_map.svh"

module ajm_sensor_nodes import ajm_pkg::*; #(
  parameter int TICK_CYCLES = `AJM_TICK_NS / `AJM_CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  ajm_link_if.node link,
  input wire logic [15:0] primary_position_sensor,
  input wire logic [15:0] redundant_position_sensor,
  input wire logic [15:0] primary_trim,
  input wire logic [15:0] redundant_trim,
  input wire logic primary_engage_switch,
  input wire logic redundant_engage_switch,
  input wire logic [7:0] tx_interval,
  input wire logic corrupt_crc
);

  ajm_node_t s_r;
  ajm_node_t s_nxt;
  ajm_frame_t f;

  always_comb begin
    s_nxt = s_r;
    f = '0;
    s_nxt.frm_valid = 1'b0;
    s_nxt.tick_cnt = s_r.tick_cnt + 20'h0_0001;
    if (s_r.tick_cnt == 20'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.ival = s_r.ival + 8'h01;
    end
    f.sender = `AJM_DEF_SENDER_ADDR;
    if (s_r.redundant_next) begin
      // Second channel follows its partner one cycle later
      f.offset = `AJM_DEF_SAFETY_OFFSET;
      f.seq = s_r.seq[1];
      f.engage = redundant_engage_switch; // [RULE_21]
      f.pos = redundant_position_sensor; // [RULE_20]
      f.trim = redundant_trim;
      f.crc = ajm_crc(f) ^ {7'h00, corrupt_crc};
      s_nxt.frm = f;
      s_nxt.frm_valid = 1'b1;
      s_nxt.seq[1] = s_r.seq[1] + 4'h1;
      s_nxt.redundant_next = 1'b0;
    end else if (s_r.tick_cnt == 20'(TICK_CYCLES - 1) && s_r.ival + 8'h01 >= tx_interval) begin
      // First frame once tx_interval ticks have elapsed, well inside the start-up window [RULE_07]
      s_nxt.ival = '0;
      f.offset = `AJM_DEF_MAIN_OFFSET;
      f.seq = s_r.seq[0];
      f.engage = primary_engage_switch; // [RULE_21]
      f.pos = primary_position_sensor; // [RULE_20]
      f.trim = primary_trim;
      f.crc = ajm_crc(f) ^ {7'h00, corrupt_crc};
      s_nxt.frm = f;
      s_nxt.frm_valid = 1'b1;
      s_nxt.seq[0] = s_r.seq[0] + 4'h1;
      s_nxt.redundant_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.frm_valid = s_r.frm_valid;
  assign link.frm = s_r.frm;

endmodule // ajm_sensor_nodes

`default_nettype wire

// >>> verif/ajm_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ajm_map.svh"

module ajm_link_chk import ajm_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic frm_valid,
  input wire ajm_frame_t frm,
  input wire logic aux_present,
  input wire logic operator_interface_command,
  input wire logic steer_en,
  input wire logic await_other_device,
  input wire logic safe_state,
  input wire logic [`AJM_FLT_W-1:0] fault_flags,
  input wire logic [15:0] main_position,
  input wire logic [15:0] safety_position,
  input wire logic signed [15:0] wheel_error,
  input wire logic signed [15:0] flow_cmd,
  input wire logic signed [15:0] spool_setpoint
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic crc_ok;
  assign crc_ok = frm.crc == (`AJM_CRC_SEED ^ frm.sender ^ frm.offset ^ {3'h0, frm.engage, frm.seq}
                  ^ frm.pos[15:8] ^ frm.pos[7:0] ^ frm.trim[15:8] ^ frm.trim[7:0]);

  // Clean frame on one channel, monitor healthy
  sequence s_prim;
    frm_valid && crc_ok && aux_present && !safe_state && frm.offset == `AJM_DEF_MAIN_OFFSET &&
      frm.sender == `AJM_DEF_SENDER_ADDR;
  endsequence
  sequence s_red;
    frm_valid && crc_ok && aux_present && !safe_state && frm.offset == `AJM_DEF_SAFETY_OFFSET &&
      frm.sender == `AJM_DEF_SENDER_ADDR;
  endsequence

  a_pair_order: assert property (s_prim |=> frm_valid && frm.offset == `AJM_DEF_SAFETY_OFFSET)
    else $error("redundant frame did not follow primary");
  a_main_takes: assert property (s_prim |=> main_position == $past(frm.pos))
    else $error("primary position not taken by main channel");
  a_safety_takes: assert property (s_red |=> safety_position == $past(frm.pos))
    else $error("redundant position not taken by safety channel");
  a_steer_needs_cmd: assert property (steer_en |-> operator_interface_command && !safe_state)
    else $error("steering without permission");
  a_await_other: assert property (await_other_device != steer_en)
    else $error("await flag not inverse of steering");
  a_safe_latched: assert property (safe_state |=> safe_state)
    else $error("safe state left without reset");
  a_safe_idle: assert property (safe_state |-> !steer_en && spool_setpoint == 16'sh0000)
    else $error("output active in safe state");
  a_fault_safe: assert property ($rose(|fault_flags) |-> ##[0:1] safe_state)
    else $error("fault without safe state");
  a_flow_half: assert property (flow_cmd == (wheel_error >>> 1))
    else $error("flow command not derived from error");
endmodule // ajm_link_chk

`default_nettype wire

// >>> verif/ajm_joy_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ajm_map.svh"

module ajm_joy_monitor_test import ajm_pkg::*;;
  logic mclk = 0;
  logic rst_n = 0;
  logic [7:0] joystick_sender_address, main_group_offset, safety_group_offset;
  logic [7:0] message_timeout_limit, position_divergence_time, engage_divergence_time;
  logic [7:0] trim_divergence_time, tx_interval;
  logic [15:0] position_difference_limit, trim_difference_limit;
  logic [15:0] primary_position_sensor, redundant_position_sensor, primary_trim, redundant_trim;
  logic primary_engage_switch, redundant_engage_switch, corrupt_crc, aux_present;
  logic operator_interface_command, joystick_on_can, single_aux_type;
  logic signed [15:0] wheel_angle_meas, wheel_error, flow_cmd, spool_setpoint;
  logic steer_en, await_other_device, safe_state;
  logic [`AJM_FLT_W-1:0] fault_flags, flags_b;
  logic [15:0] main_position, safety_position;
  int fails = 0;
  int compares = 0;
  int cyc = 0;

  ajm_link_if link_a();
  ajm_link_if link_b();

  ajm_sensor_nodes #(.TICK_CYCLES(10)) ajm_sensor_nodes_i(.mclk, .rst_n, .link(link_a),
    .primary_position_sensor, .redundant_position_sensor, .primary_trim, .redundant_trim,
    .primary_engage_switch, .redundant_engage_switch, .tx_interval, .corrupt_crc);
  ajm_joy_monitor #(.TICK_CYCLES(10)) ajm_joy_monitor_i(.mclk, .rst_n, .link(link_a),
    .joystick_sender_address, .main_group_offset, .safety_group_offset, .message_timeout_limit,
    .position_divergence_time, .position_difference_limit, .engage_divergence_time,
    .trim_divergence_time, .trim_difference_limit, .aux_present, .operator_interface_command,
    .joystick_on_can, .single_aux_type, .wheel_angle_meas, .steer_en, .await_other_device,
    .safe_state, .fault_flags, .main_position, .safety_position, .wheel_error, .flow_cmd,
    .spool_setpoint);
  // Second monitor fed by a bench driver that breaks the frame rules
  ajm_joy_monitor #(.TICK_CYCLES(10)) ajm_joy_monitor_i2(.mclk, .rst_n, .link(link_b),
    .joystick_sender_address, .main_group_offset, .safety_group_offset, .message_timeout_limit,
    .position_divergence_time, .position_difference_limit, .engage_divergence_time,
    .trim_divergence_time, .trim_difference_limit, .aux_present, .operator_interface_command,
    .joystick_on_can, .single_aux_type, .wheel_angle_meas, .steer_en(), .await_other_device(),
    .safe_state(), .fault_flags(flags_b), .main_position(), .safety_position(), .wheel_error(),
    .flow_cmd(), .spool_setpoint());
  ajm_link_chk ajm_link_chk_i(.mclk, .rst_n, .frm_valid(link_a.frm_valid), .frm(link_a.frm),
    .aux_present, .operator_interface_command, .steer_en, .await_other_device, .safe_state,
    .fault_flags, .main_position, .safety_position, .wheel_error, .flow_cmd, .spool_setpoint);

  always #50 mclk = ~mclk;

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n * 10) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset;
    rst_n = 0;
    joystick_sender_address = 8'h4E;
    main_group_offset = 8'h16;
    safety_group_offset = 8'h17;
    message_timeout_limit = 8'h08;
    position_divergence_time = 8'h0A;
    engage_divergence_time = 8'h0A;
    trim_divergence_time = 8'h0A;
    position_difference_limit = 16'h0005;
    trim_difference_limit = 16'h0032;
    primary_position_sensor = 16'h021C;
    redundant_position_sensor = 16'h021C;
    primary_trim = 16'h0064;
    redundant_trim = 16'h0064;
    primary_engage_switch = 1;
    redundant_engage_switch = 1;
    operator_interface_command = 1;
    joystick_on_can = 0;
    single_aux_type = 1;
    aux_present = 1;
    tx_interval = 8'h01;
    corrupt_crc = 0;
    wheel_angle_meas = 16'sh0000;
    link_b.frm_valid = 0;
    link_b.frm = '0;
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1;
  endtask

  task automatic send_b(input logic [7:0] s, input logic [7:0] o, input logic [3:0] q,
                        input logic [15:0] p);
    ajm_frame_t f;
    f = '{s, o, q, 1'b1, p, 16'h0064, 8'h00};
    f.crc = 8'hA5 ^ s ^ o ^ {3'h0, 1'b1, q} ^ p[15:8] ^ p[7:0] ^ 8'h64;
    link_b.frm = f;
    link_b.frm_valid = 1;
    @(posedge mclk);
    #1;
  endtask

  task automatic idle_b;
    link_b.frm_valid = 0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic t_steer;
    do_reset;
    ticks(3);
    chk("steer_no_can", 16'h0000, 16'(steer_en));
    joystick_on_can = 1;
    ticks(3);
    chk("steer_on", 16'h0001, 16'(steer_en));
    chk("main_pos", 16'h021C, main_position);
    chk("safety_pos", 16'h021C, safety_position);
    chk("wheel_err", 16'h0028, wheel_error);
    chk("flow", 16'h0014, flow_cmd);
    chk("spool", 16'h0014, spool_setpoint);
    operator_interface_command = 0;
    #1;
    chk("steer_prohibit", 16'h0000, 16'(steer_en));
    chk("await", 16'h0001, 16'(await_other_device));
    operator_interface_command = 1;
    primary_position_sensor = 16'h0258;
    redundant_position_sensor = 16'h0258;
    ticks(10);
    chk("fda_flag", 16'h0020, 16'(fault_flags));
    chk("fda_safe", 16'h0001, 16'(safe_state));
    chk("fda_spool", 16'h0000, spool_setpoint);
  endtask

  task automatic t_position;
    do_reset;
    redundant_position_sensor = 16'h0222;
    ticks(8);
    redundant_position_sensor = 16'h021C;
    ticks(3);
    redundant_position_sensor = 16'h0222;
    ticks(8);
    chk("pos_restart", 16'h0000, 16'(fault_flags));
    ticks(8);
    chk("pos_div", 16'h0010, 16'(fault_flags));
  endtask

  task automatic t_engage_trim;
    do_reset;
    redundant_engage_switch = 0;
    ticks(8);
    chk("eng_early", 16'h0000, 16'(fault_flags));
    ticks(8);
    chk("eng_div", 16'h0010, 16'(fault_flags));
    do_reset;
    redundant_trim = 16'h0097;
    ticks(8);
    chk("trim_early", 16'h0000, 16'(fault_flags));
    ticks(8);
    chk("trim_div", 16'h0010, 16'(fault_flags));
  endtask

  task automatic t_timeout_crc;
    do_reset;
    tx_interval = 8'h05;
    ticks(40);
    chk("nominal_pos", 16'h021C, main_position);
    chk("tmo_nominal", 16'h0000, 16'(fault_flags));
    do_reset;
    ticks(2);
    // Pairs seen, then the sender falls silent
    tx_interval = 8'h14;
    ticks(7);
    chk("tmo_early", 16'h0000, 16'(fault_flags));
    ticks(1);
    chk("tmo", 16'h0001, 16'(fault_flags));
    do_reset;
    operator_interface_command = 0;
    corrupt_crc = 1;
    ticks(3);
    chk("crc_prohibited", 16'h0004, 16'(fault_flags));
    do_reset;
    aux_present = 0;
    corrupt_crc = 1;
    ticks(3);
    chk("crc_absent", 16'h0000, 16'(fault_flags));
  endtask

  task automatic t_frames;
    do_reset;
    send_b(8'h4F, 8'h16, 4'h0, 16'h03E9);
    send_b(8'h4E, 8'h18, 4'h0, 16'h03E9);
    idle_b;
    chk("foreign_ignored", 16'h0000, 16'(flags_b));
    send_b(8'h4E, 8'h16, 4'h0, 16'h01F4);
    send_b(8'h4E, 8'h17, 4'h0, 16'h01F4);
    idle_b;
    send_b(8'h4E, 8'h16, 4'h1, 16'h01F4);
    send_b(8'h4E, 8'h17, 4'h3, 16'h01F4);
    idle_b;
    chk("seq_redundant", 16'h0002, 16'(flags_b));
    do_reset;
    send_b(8'h4E, 8'h16, 4'h0, 16'h03E9);
    idle_b;
    chk("range", 16'h0008, 16'(flags_b));
  endtask

  task automatic t_startup;
    // Second monitor never sees a frame: start-up window runs out
    do_reset;
    ticks(999);
    chk("startup_early", 16'h0000, 16'(flags_b));
    ticks(1);
    chk("startup_tmo", 16'h0001, 16'(flags_b));
  endtask

  initial begin
    t_steer;
    t_position;
    t_engage_trim;
    t_timeout_crc;
    t_frames;
    t_startup;
    print_verdict;
  end
endmodule // ajm_joy_monitor_test

`default_nettype wire
